/* src/cucs_defs.svh */
// Register addresses, field positions and reset values of the calculation unit command port.
`ifndef CUCS_DEFS_SVH
`define CUCS_DEFS_SVH
`define CUCS_ADDR_CMD 8'h99
`define CUCS_ADDR_CALC_COMMAND_STATUS 8'h98
`define CUCS_CMD_RESET 8'h00
`define CUCS_CALC_COMMAND_STATUS_RESET 5'h00
`define CUCS_CMD_READY_BIT 0
`define CUCS_CMD_WIDTH32_BIT 1
`define CUCS_CMD_LOAD_RAM_BIT 2
`define CUCS_CMD_SHIFT_BIT 3
`define CUCS_ST_DONE_BIT 0
`define CUCS_ST_CARRY_BIT 1
`define CUCS_ST_RUN_BIT 2
`define CUCS_ST_RD_DIS_SECOND_BIT 3
`define CUCS_ST_RD_DIS_FIRST_BIT 4
`define CUCS_OPERAND_BYTES_WIDE 3'h4
`define CUCS_OPERAND_BYTES_NARROW 3'h3
`endif

/* src/cucs_pkg.sv */
// Types shared by the calculation unit command port.
package cucs_pkg;
    typedef enum logic [1:0] {
        CUCS_IDLE,
        CUCS_LOAD,
        CUCS_RUN
    } cucs_state_e;
    typedef logic [7:0] cucs_byte_t;
endpackage : cucs_pkg

/* src/cucs_cmd_status.sv */
// Command and status sequencer of the calculation unit with its two special function registers.
`timescale 1ns/1ps
`include "cucs_defs.svh"
// What this block does
// - Shift set: result leaves through three stages.
// - Shift clear: result goes straight to output.
// - Load bit set: operands reload from RAM.
// - Load bit clear: operands reload from pipeline.
// - Narrow mode with RAM load: three operand bytes, pointer plus three.
// - Command ready clears when calculation starts.
// - Ready set while running chains next calculation.
// - Chained end raises no completion.
// - First read disable: zero operand, counter held.
// - Second read disable: zero operand, counter held.
// - Running bit follows activity, not writable.
// - Carry shows nonzero output pipeline.
// - End sets completion; completion drives interrupt.
// - Top three status bits ignore writes.
// - Seven command bits shadowed at each start.
// - Reset clears both registers.
// - Calculation ends when byte counter reaches zero.
module cucs_cmd_status
    import cucs_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    input wire logic I_MULT_PTR_WR,
    input wire logic [7:0] I_MULT_PTR_VAL,
    input wire logic [7:0] I_MULT_DATA,
    output logic [7:0] O_MULT_ADDR,
    output logic [31:0] O_MULT_OPERAND,
    input wire logic [7:0] I_FIRST_START,
    input wire logic [7:0] I_SECOND_START,
    input wire logic [7:0] I_FIRST_DATA,
    input wire logic [7:0] I_SECOND_DATA,
    output logic [7:0] O_FIRST_ADDR,
    output logic [7:0] O_SECOND_ADDR,
    output logic [7:0] O_FIRST_OPERAND,
    output logic [7:0] O_SECOND_OPERAND,
    input wire logic I_STEP,
    input wire logic I_COUNT_ZERO,
    input wire logic [7:0] I_RESULT_BYTE,
    output logic [7:0] O_OUTPUT_RESULT,
    output logic [6:0] O_SEQ_CMD,
    output logic O_RUNNING,
    output logic O_IRQ
);
    // ****************************************
    // Registers and state.
    // ****************************************
    cucs_state_e state;
    logic [7:0] command;
    logic [6:0] shadow;
    logic first_operand_read_disable;
    logic second_operand_read_disable;
    logic nonzero_result_carry;
    logic done;
    logic [7:0] out_pipe [4];
    logic [7:0] a_reg [4];
    logic [2:0] load_idx;
    logic [7:0] multiplier_operand_pointer;
    logic cmd_wr;
    logic stat_wr;
    logic start;
    logic calc_end;
    logic chain;
    logic [2:0] load_len;
    logic shift_on;

    assign cmd_wr = I_SFR_WR && (I_SFR_ADDR == `CUCS_ADDR_CMD);
    assign stat_wr = I_SFR_WR && (I_SFR_ADDR == `CUCS_ADDR_CALC_COMMAND_STATUS);
    assign calc_end = (state == CUCS_RUN) && I_STEP && I_COUNT_ZERO;
    assign chain = calc_end && command[`CUCS_CMD_READY_BIT];
    assign start = ((state == CUCS_IDLE) && command[`CUCS_CMD_READY_BIT]) || chain;
    assign shift_on = shadow[`CUCS_CMD_SHIFT_BIT - 1];
    assign load_len = shadow[`CUCS_CMD_WIDTH32_BIT - 1] ? `CUCS_OPERAND_BYTES_WIDE
                                                       : `CUCS_OPERAND_BYTES_NARROW;

    // ****************************************
    // Sequencer.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            state <= CUCS_IDLE;
        end else if (start) begin
            state <= CUCS_LOAD;
        end else if (state == CUCS_LOAD) begin
            if (!shadow[`CUCS_CMD_LOAD_RAM_BIT - 1] || (load_idx == load_len - 3'h1)) begin
                state <= CUCS_RUN;
            end
        end else if (calc_end) begin
            state <= CUCS_IDLE;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_RUNNING <= 1'b0;
        end else begin
            O_RUNNING <= start || (state != CUCS_IDLE && !calc_end);
        end
    end

    // ****************************************
    // Command register and shadow.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            command <= `CUCS_CMD_RESET;
        end else if (cmd_wr) begin
            command <= I_SFR_WDATA;
        end else if (start) begin
            command[`CUCS_CMD_READY_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            shadow <= 7'h00;
        end else if (start) begin
            shadow <= command[7:1];
        end
    end
    assign O_SEQ_CMD = shadow;

    // ****************************************
    // Status register.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            first_operand_read_disable <= 1'b0;
            second_operand_read_disable <= 1'b0;
        end else if (stat_wr) begin
            first_operand_read_disable <= I_SFR_WDATA[`CUCS_ST_RD_DIS_FIRST_BIT];
            second_operand_read_disable <= I_SFR_WDATA[`CUCS_ST_RD_DIS_SECOND_BIT];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            done <= 1'b0;
        end else if (calc_end && !chain) begin
            done <= 1'b1;
        end else if (stat_wr && !I_SFR_WDATA[`CUCS_ST_DONE_BIT]) begin
            done <= 1'b0;
        end
    end
    assign O_IRQ = done;

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            nonzero_result_carry <= 1'b0;
        end else begin
            nonzero_result_carry <= |{out_pipe[3], out_pipe[2], out_pipe[1], out_pipe[0]};
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_SFR_RDATA <= 8'h00;
        end else if (I_SFR_RD) begin
            if (I_SFR_ADDR == `CUCS_ADDR_CMD) begin
                O_SFR_RDATA <= command;
            end else if (I_SFR_ADDR == `CUCS_ADDR_CALC_COMMAND_STATUS) begin
                O_SFR_RDATA <= {3'h0, first_operand_read_disable, second_operand_read_disable,
                                O_RUNNING, nonzero_result_carry, done};
            end else begin
                O_SFR_RDATA <= 8'h00;
            end
        end
    end

    // ****************************************
    // Output pipeline.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            for (int i = 0; i < 4; i++) begin
                out_pipe[i] <= 8'h00;
            end
            O_OUTPUT_RESULT <= 8'h00;
        end else if ((state == CUCS_RUN) && I_STEP) begin
            out_pipe[3] <= I_RESULT_BYTE;
            if (shift_on) begin
                for (int i = 0; i < 3; i++) begin
                    out_pipe[i] <= out_pipe[i + 1];
                end
                O_OUTPUT_RESULT <= out_pipe[1];
            end else begin
                O_OUTPUT_RESULT <= I_RESULT_BYTE;
            end
        end
    end

    // ****************************************
    // Multiplier operand load.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            load_idx <= 3'h0;
        end else if (start) begin
            load_idx <= 3'h0;
        end else if (state == CUCS_LOAD) begin
            load_idx <= load_idx + 3'h1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            multiplier_operand_pointer <= 8'h00;
        end else if (I_MULT_PTR_WR) begin
            multiplier_operand_pointer <= I_MULT_PTR_VAL;
        end else if (state == CUCS_LOAD && shadow[`CUCS_CMD_LOAD_RAM_BIT - 1]) begin
            multiplier_operand_pointer <= multiplier_operand_pointer + 8'h01;
        end
    end
    assign O_MULT_ADDR = multiplier_operand_pointer;

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            for (int i = 0; i < 4; i++) begin
                a_reg[i] <= 8'h00;
            end
        end else if (state == CUCS_LOAD) begin
            if (shadow[`CUCS_CMD_LOAD_RAM_BIT - 1]) begin
                a_reg[load_idx[1:0]] <= I_MULT_DATA;
                if (load_idx == 3'h0 && load_len == `CUCS_OPERAND_BYTES_NARROW) begin
                    a_reg[3] <= 8'h00;
                end
            end else begin
                for (int i = 0; i < 4; i++) begin
                    a_reg[i] <= out_pipe[i];
                end
            end
        end
    end
    assign O_MULT_OPERAND = {a_reg[3], a_reg[2], a_reg[1], a_reg[0]};

    // ****************************************
    // Input operand fetch.
    // ****************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_FIRST_ADDR <= 8'h00;
            O_FIRST_OPERAND <= 8'h00;
        end else if (start) begin
            O_FIRST_ADDR <= I_FIRST_START;
        end else if ((state == CUCS_RUN) && I_STEP) begin
            if (first_operand_read_disable) begin
                O_FIRST_OPERAND <= 8'h00;
            end else begin
                O_FIRST_OPERAND <= I_FIRST_DATA;
                O_FIRST_ADDR <= O_FIRST_ADDR - 8'h01;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_SECOND_ADDR <= 8'h00;
            O_SECOND_OPERAND <= 8'h00;
        end else if (start) begin
            O_SECOND_ADDR <= I_SECOND_START;
        end else if ((state == CUCS_RUN) && I_STEP) begin
            if (second_operand_read_disable) begin
                O_SECOND_OPERAND <= 8'h00;
            end else begin
                O_SECOND_OPERAND <= I_SECOND_DATA;
                O_SECOND_ADDR <= O_SECOND_ADDR - 8'h01;
            end
        end
    end

    // ****************************************
    // Checks.
    // ****************************************
    property p_shift_out;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == CUCS_RUN && I_STEP && shift_on) |=> O_OUTPUT_RESULT == $past(out_pipe[1]);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("Shifted output not from pipe stage.");

    property p_plain_out;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == CUCS_RUN && I_STEP && !shift_on) |=> O_OUTPUT_RESULT == $past(I_RESULT_BYTE);
    endproperty
    a_plain_out: assert property (p_plain_out) else $error("Unshifted output wrong.");

    property p_ready_clear;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (start && !cmd_wr) |=> !command[`CUCS_CMD_READY_BIT] && state == CUCS_LOAD;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("Command ready not cleared at start.");

    property p_chain;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        chain |=> state == CUCS_LOAD && O_RUNNING && $stable(done);
    endproperty
    a_chain: assert property (p_chain) else $error("Chained calculation did not restart cleanly.");

    property p_done_set;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (calc_end && !chain) |=> done && O_IRQ && !O_RUNNING;
    endproperty
    a_done_set: assert property (p_done_set) else $error("Completion not raised at end.");

    property p_first_hold;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == CUCS_RUN && I_STEP && first_operand_read_disable && !start)
            |=> $stable(O_FIRST_ADDR) && O_FIRST_OPERAND == 8'h00;
    endproperty
    a_first_hold: assert property (p_first_hold) else $error("First operand fetched while disabled.");

    property p_second_hold;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (state == CUCS_RUN && I_STEP && second_operand_read_disable && !start)
            |=> $stable(O_SECOND_ADDR) && O_SECOND_OPERAND == 8'h00;
    endproperty
    a_second_hold: assert property (p_second_hold) else $error("Second operand fetched while disabled.");

    property p_carry;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        ##1 nonzero_result_carry == ($past(out_pipe[3]) != 8'h00 || $past(out_pipe[2]) != 8'h00
                                    || $past(out_pipe[1]) != 8'h00 || $past(out_pipe[0]) != 8'h00);
    endproperty
    a_carry: assert property (p_carry) else $error("Carry does not match output pipeline.");

    property p_ram_load_len;
        @(posedge I_CLOCK) disable iff (!I_NRST)
        (start && command[`CUCS_CMD_LOAD_RAM_BIT] && !I_MULT_PTR_WR) ##1 (!I_MULT_PTR_WR) [*5]
            |-> multiplier_operand_pointer == $past(multiplier_operand_pointer, 5)
                + ($past(shadow[`CUCS_CMD_WIDTH32_BIT - 1], 4) ? 8'h04 : 8'h03);
    endproperty
    a_ram_load_len: assert property (p_ram_load_len) else $error("Operand pointer advance wrong.");
endmodule : cucs_cmd_status

/* bench/cucs_far_model.sv */
// Far side model: on-chip RAM seen by the multiplier pointer and the two operand counters.
`timescale 1ns/1ps
// ****************************************
// Combinational RAM read
// ****************************************
module cucs_far_model (
    input wire logic [7:0] i_mult_addr,
    input wire logic [7:0] i_first_addr,
    input wire logic [7:0] i_second_addr,
    output logic [7:0] o_mult_data,
    output logic [7:0] o_first_data,
    output logic [7:0] o_second_data
);
    assign o_mult_data = i_mult_addr * 8'h1d + 8'h5a;
    assign o_first_data = i_first_addr * 8'h1d + 8'h5a;
    assign o_second_data = i_second_addr * 8'h1d + 8'h5a;
endmodule : cucs_far_model

/* bench/calc_unit_command_status_tb.sv */
// Self-checking testbench of the calculation unit command and status port.
`timescale 1ns/1ps
`include "cucs_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module calc_unit_command_status_tb import cucs_pkg::*;;
    logic clk, nrst, wr, rd, ptr_wr, step, zero, running, irq, chn, chn0;
    cucs_byte_t addr, wdata, rdata, ptr_val, mdata, fstart, sstart, fdata, sdata;
    cucs_byte_t maddr, faddr, saddr, fop, sop, rbyte, outres, v, p;
    cucs_byte_t cmd, nxt, len, fa, sa, efop, esop, eout;
    cucs_byte_t pipe [4];
    logic [1:0] dis;
    logic [31:0] mop, seed, em;
    logic [6:0] seq;
    int bad_count, compares, n;

    cucs_cmd_status dut_u (.I_CLOCK(clk), .I_NRST(nrst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd),
        .I_SFR_WDATA(wdata), .O_SFR_RDATA(rdata), .I_MULT_PTR_WR(ptr_wr), .I_MULT_PTR_VAL(ptr_val),
        .I_MULT_DATA(mdata), .O_MULT_ADDR(maddr), .O_MULT_OPERAND(mop), .I_FIRST_START(fstart),
        .I_SECOND_START(sstart), .I_FIRST_DATA(fdata), .I_SECOND_DATA(sdata), .O_FIRST_ADDR(faddr),
        .O_SECOND_ADDR(saddr), .O_FIRST_OPERAND(fop), .O_SECOND_OPERAND(sop), .I_STEP(step),
        .I_COUNT_ZERO(zero), .I_RESULT_BYTE(rbyte), .O_OUTPUT_RESULT(outres), .O_SEQ_CMD(seq),
        .O_RUNNING(running), .O_IRQ(irq));
    cucs_far_model far_u (.i_mult_addr(maddr), .i_first_addr(faddr), .i_second_addr(saddr),
        .o_mult_data(mdata), .o_first_data(fdata), .o_second_data(sdata));

    // ********
    // Helpers.
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic cucs_byte_t mem(input cucs_byte_t a);
        return a * 8'h1d + 8'h5a;
    endfunction : mem

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic sfr_wr(input cucs_byte_t a, input cucs_byte_t d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : sfr_wr

    task automatic sfr_rd(input cucs_byte_t a, output cucs_byte_t d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : sfr_rd

    task automatic do_step(input logic z, input logic c);
        seed = lfsr(seed);
        rbyte <= seed[7:0];
        step <= 1'b1;
        zero <= z;
        eout = seed[7:0];
        if (cmd[`CUCS_CMD_SHIFT_BIT]) begin
            eout = pipe[1];
            pipe[0] = pipe[1];
            pipe[1] = pipe[2];
            pipe[2] = pipe[3];
        end
        pipe[3] = seed[7:0];
        if (c) begin
            fa = fstart;
            sa = sstart;
        end else begin
            efop = dis[1] ? 8'h00 : mem(fa);
            esop = dis[0] ? 8'h00 : mem(sa);
            fa = dis[1] ? fa : fa - 8'h01;
            sa = dis[0] ? sa : sa - 8'h01;
        end
        @(posedge clk);
        step <= 1'b0;
        zero <= 1'b0;
        @(negedge clk);
        `CHK("output_result", eout, outres)
        `CHK("first_operand", efop, fop)
        `CHK("first_addr", fa, faddr)
        `CHK("second_operand", esop, sop)
        `CHK("second_addr", sa, saddr)
    endtask : do_step

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #100000;
        bad_count++;
        end_sim();
    end

    initial begin
        seed = 32'h0001405b;
        {nrst, wr, rd, ptr_wr, step, zero} = 6'h00;
        {addr, wdata, ptr_val, fstart, sstart, rbyte} = '0;
        for (int i = 0; i < 4; i++) begin
            pipe[i] = 8'h00;
        end
        efop = 8'h00;
        esop = 8'h00;
        chn = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        sfr_rd(`CUCS_ADDR_CMD, v);
        `CHK("cmd_reset", 8'h00, v)
        sfr_rd(`CUCS_ADDR_CALC_COMMAND_STATUS, v);
        `CHK("stat_reset", 8'h00, v)
        sfr_wr(`CUCS_ADDR_CALC_COMMAND_STATUS, 8'hff);
        sfr_rd(`CUCS_ADDR_CALC_COMMAND_STATUS, v);
        `CHK("stat_all_ones", 8'h18, v)
        sfr_rd(8'h42, v);
        `CHK("unmapped", 8'h00, v)
        for (int it = 0; it < 40; it++) begin
            if (!chn) begin
                seed = lfsr(seed);
                dis = seed[9:8];
                fstart <= seed[23:16];
                sstart <= seed[31:24];
                ptr_val <= seed[7:0];
                ptr_wr <= 1'b1;
                p = seed[7:0];
                sfr_wr(`CUCS_ADDR_CALC_COMMAND_STATUS, {3'h0, dis, 3'h0});
                ptr_wr <= 1'b0;
                sfr_rd(`CUCS_ADDR_CALC_COMMAND_STATUS, v);
                `CHK("done_clear", 1'b0, v[`CUCS_ST_DONE_BIT])
                `CHK("read_disables", dis, v[4:3])
                seed = lfsr(seed);
                cmd = {4'h0, seed[3:1], 1'b1};
                fa = fstart;
                sa = sstart;
                sfr_wr(`CUCS_ADDR_CMD, cmd);
                @(negedge clk);
            end
            `CHK("running_load", 1'b1, running)
            len = cmd[`CUCS_CMD_LOAD_RAM_BIT] ? (cmd[`CUCS_CMD_WIDTH32_BIT] ? 8'h04 : 8'h03) : 8'h01;
            repeat (len) @(posedge clk);
            @(negedge clk);
            `CHK("seq_cmd", cmd[7:1], seq)
            v = cmd[`CUCS_CMD_LOAD_RAM_BIT] ? p + len : p;
            `CHK("mult_addr", v, maddr)
            for (int i = 0; i < 4; i++) begin
                em[8*i +: 8] = !cmd[`CUCS_CMD_LOAD_RAM_BIT] ? pipe[i] : (i < len ? mem(p + 8'(i)) : 8'h00);
            end
            `CHK("mult_operand", em, mop)
            p = v;
            seed = lfsr(seed);
            n = seed[1:0];
            nxt = {4'h0, seed[6:4], 1'b1};
            chn0 = seed[8] && it < 39;
            for (int k = 0; k < n; k++) begin
                @(posedge clk);
                do_step(1'b0, 1'b0);
            end
            @(posedge clk);
            if (chn0) begin
                sfr_wr(`CUCS_ADDR_CMD, nxt);
            end
            do_step(1'b1, chn0);
            `CHK("irq_end", !chn0, irq)
            `CHK("running_end", chn0, running)
            if (chn0) begin
                cmd = nxt;
            end else begin
                @(posedge clk);
                sfr_rd(`CUCS_ADDR_CALC_COMMAND_STATUS, v);
                `CHK("stat_end", {3'h0, dis, 1'b0, |{pipe[3], pipe[2], pipe[1], pipe[0]}, 1'b1}, v)
                sfr_rd(`CUCS_ADDR_CMD, v);
                `CHK("cmd_end", cmd & 8'hfe, v)
            end
            chn = chn0;
        end
        end_sim();
    end
endmodule : calc_unit_command_status_tb
